// File: include/amc_pkg.sv
// Contract
// - Five-bit analog attenuation in half-decibel steps, zero is full gain, all-ones -15.5 dB.
// - Software sets first-coefficient flag; the next coefficient write starts a new biquad.
// - Modulator frequency bit selects fast rate when clear, half rate when set; resets set.
// - Dither enable: 00 none, 01 main, 10 second, 11 both stages.
// - Dither level codes 100-111 give 2^-7 to 2^-10, 000-011 give 2^-13 to 2^-16.
// - Element matching select enables matching at 00, disables at 11.
// - Direction bit makes the address pin input when clear, output when set.
// - Pin function field selects low, mute flags, clock-invalid or fault output on pin.
// - Sharing bit clear makes right reuse left coefficients; set gives unique coefficients.
// - Bypass bit routes audio around the finite impulse response stage.
// - Compressor bypass skips range compression in left and right main channels only.
// - Equalizer bypass skips equalizer filters in left and right main channels only.
// - Eight-bit read-only silicon identifier register.
// - Read-only power state code: 0 deep sleep, 1 sleep, 2 high impedance, 3 play.
// - Read-only status bit reads one while right channel is auto muted.
// - Read-only status bit reads one while left channel is auto muted.
package amc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ANALOG_GAIN = 8'h54;
    localparam logic [7:0] ADDR_BIQUAD_MARK = 8'h5C;
    localparam logic [7:0] ADDR_CONV_MOD = 8'h5D;
    localparam logic [7:0] ADDR_PIN_DIR = 8'h60;
    localparam logic [7:0] ADDR_PIN_FUNC = 8'h61;
    localparam logic [7:0] ADDR_PROC_BYPASS = 8'h66;
    localparam logic [7:0] ADDR_SILICON_ID = 8'h67;
    localparam logic [7:0] ADDR_POWER_STATE = 8'h68;
    localparam logic [7:0] ADDR_MUTE_STATUS = 8'h69;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ANALOG_GAIN = 8'h00;
    localparam logic [7:0] RST_BIQUAD_MARK = 8'h00;
    localparam logic [7:0] RST_CONV_MOD = 8'hF8;
    localparam logic [7:0] RST_PIN_DIR = 8'h00;
    localparam logic [7:0] RST_PIN_FUNC = 8'h00;
    localparam logic [7:0] RST_PROC_BYPASS = 8'h00;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int GAIN_W = 5;
    localparam int FREQ_SEL_BIT = 7;
    localparam int DITHER_EN_LSB = 5;
    localparam int DITHER_LVL_LSB = 2;
    localparam int MATCH_SEL_LSB = 0;
    localparam int SHARE_BIT = 3;
    localparam int FIR_BYP_BIT = 2;
    localparam int COMP_BYP_BIT = 1;
    localparam int EQ_BYP_BIT = 0;
    localparam int FUNC_W = 5;

    // ------------------------------------------------------------
    // Pin function codes
    // ------------------------------------------------------------
    localparam logic [4:0] PIN_FN_LOW = 5'h00;
    localparam logic [4:0] PIN_FN_MUTE_BOTH = 5'h03;
    localparam logic [4:0] PIN_FN_MUTE_LEFT = 5'h04;
    localparam logic [4:0] PIN_FN_MUTE_RIGHT = 5'h05;
    localparam logic [4:0] PIN_FN_CLK_INVALID = 5'h06;
    localparam logic [4:0] PIN_FN_FAULT = 5'h0B;

    // Power state codes
    localparam logic [7:0] PWR_DEEP_SLEEP = 8'h00;
    localparam logic [7:0] PWR_SLEEP = 8'h01;
    localparam logic [7:0] PWR_HIGH_IMPEDANCE = 8'h02;
    localparam logic [7:0] PWR_PLAY = 8'h03;

    // Identifier value is arbitrary
    localparam logic [7:0] SILICON_ID_DEFAULT = 8'h5A;

endpackage : amc_pkg

// File: src/amc_sync2.sv
module amc_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // ------------------------------------------------------------
    // Two-stage synchroniser
    // ------------------------------------------------------------
    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge clock) begin
        if (srst) begin
            stage1 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end

endmodule : amc_sync2

// File: src/amc_pin_mux.sv
module amc_pin_mux
    import amc_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Configuration
    input wire logic pin_output_enable,
    input wire logic [amc_pkg::FUNC_W-1:0] pin_function,
    // Flag sources
    input wire logic left_muted,
    input wire logic right_muted,
    input wire logic clock_invalid,
    input wire logic fault_out_n,
    // Pin
    output logic addr_pin_o,
    output logic addr_pin_oe
);

    // ------------------------------------------------------------
    // Function select
    // ------------------------------------------------------------
    logic next_pin;

    // Reserved codes drive low, same as off
    always_comb begin
        case (pin_function)
            PIN_FN_LOW: next_pin = 1'b0;
            PIN_FN_MUTE_BOTH: next_pin = left_muted & right_muted;
            PIN_FN_MUTE_LEFT: next_pin = left_muted;
            PIN_FN_MUTE_RIGHT: next_pin = right_muted;
            PIN_FN_CLK_INVALID: next_pin = clock_invalid;
            PIN_FN_FAULT: next_pin = fault_out_n;
            default: next_pin = 1'b0;
        endcase
    end

    // Registered pin drive avoids glitches from mux changes
    always_ff @(posedge clock) begin
        if (srst) begin
            addr_pin_o <= 1'b0;
            addr_pin_oe <= 1'b0;
        end else begin
            addr_pin_o <= next_pin;
            addr_pin_oe <= pin_output_enable;
        end
    end

    pin_follow_a: assert property (@(posedge clock) disable iff (srst)
        (pin_function == PIN_FN_MUTE_LEFT) |=> (addr_pin_o == $past(left_muted)))
        else $error("address pin not following left mute flag");
    pin_dir_a: assert property (@(posedge clock) disable iff (srst)
        pin_output_enable |=> addr_pin_oe)
        else $error("address pin not driven when set to output");

endmodule : amc_pin_mux

// File: src/amc_misc_regs.sv
module amc_misc_regs
    import amc_pkg::*;
#(
    parameter logic [7:0] SILICON_ID = amc_pkg::SILICON_ID_DEFAULT
) (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Control port register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Coefficient write path
    input wire logic coef_wr,
    output logic biquad_new,
    // Analog and modulator controls
    output logic [amc_pkg::GAIN_W-1:0] analog_attenuation,
    output logic mod_half_rate,
    output logic dither_main_en,
    output logic dither_second_en,
    output logic [2:0] dither_level,
    output logic [1:0] element_matching_select,
    output logic element_matching,
    // Processing controls
    output logic coef_unique,
    output logic fir_bypass,
    output logic range_compressor_bypass,
    output logic eq_bypass,
    // Status sources from the device core
    input wire logic [1:0] power_state_code,
    input wire logic left_mute_in,
    input wire logic right_mute_in,
    input wire logic clock_invalid_in,
    input wire logic fault_in_n,
    // Address pin
    output logic addr_pin_o,
    output logic addr_pin_oe
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] analog_gain_control;
    logic [7:0] biquad_write_marker;
    logic [7:0] converter_mod_control;
    logic [7:0] addr_pin_direction;
    logic [7:0] addr_pin_function;
    logic [7:0] processing_bypass;
    logic [7:0] power_state_report;
    logic [1:0] mute_status;
    logic [1:0] status_sync;
    logic [1:0] flag_sync;
    logic right_muted_status;
    logic left_muted_status;
    logic first_pending;

    // Returns true for a write at the given offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = reg_wr && (a == off);
    endfunction : hit

    // ------------------------------------------------------------
    // Status synchronisers
    // ------------------------------------------------------------
    amc_sync2 #(.WIDTH(2)) u_mute_sync (
        .clock(clock),
        .srst(srst),
        .din({right_mute_in, left_mute_in}),
        .dout(status_sync)
    );

    amc_sync2 #(.WIDTH(2)) u_flag_sync (
        .clock(clock),
        .srst(srst),
        .din({clock_invalid_in, fault_in_n}),
        .dout(flag_sync)
    );

    // Status register follows the synchronised mute levels
    always_ff @(posedge clock) begin
        if (srst) begin
            mute_status <= 2'h0;
        end else begin
            mute_status <= status_sync;
        end
    end

    assign right_muted_status = mute_status[1];
    assign left_muted_status = mute_status[0];

    // Power state is core state, only sampled here
    always_ff @(posedge clock) begin
        if (srst) begin
            power_state_report <= PWR_DEEP_SLEEP;
        end else begin
            power_state_report <= {6'h00, power_state_code};
        end
    end

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    // Reserved bits are kept writable as read/write storage
    always_ff @(posedge clock) begin
        if (srst) begin
            analog_gain_control <= RST_ANALOG_GAIN;
            converter_mod_control <= RST_CONV_MOD;
            addr_pin_direction <= RST_PIN_DIR;
            addr_pin_function <= RST_PIN_FUNC;
            processing_bypass <= RST_PROC_BYPASS;
        end else begin
            // Read-only and unmapped offsets have no write decode
            if (hit(reg_addr, ADDR_ANALOG_GAIN)) begin
                analog_gain_control <= reg_wdata;
            end
            if (hit(reg_addr, ADDR_CONV_MOD)) begin
                converter_mod_control <= reg_wdata;
            end
            if (hit(reg_addr, ADDR_PIN_DIR)) begin
                addr_pin_direction <= reg_wdata;
            end
            if (hit(reg_addr, ADDR_PIN_FUNC)) begin
                addr_pin_function <= reg_wdata;
            end
            if (hit(reg_addr, ADDR_PROC_BYPASS)) begin
                processing_bypass <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Biquad first-coefficient marker
    // ------------------------------------------------------------
    // Marker arms a pending flag; next coefficient write starts a biquad
    always_ff @(posedge clock) begin
        if (srst) begin
            biquad_write_marker <= RST_BIQUAD_MARK;
            first_pending <= 1'b0;
            biquad_new <= 1'b0;
        end else begin
            biquad_new <= coef_wr && first_pending;
            if (hit(reg_addr, ADDR_BIQUAD_MARK)) begin
                biquad_write_marker <= reg_wdata;
                first_pending <= reg_wdata[0];
            end else if (coef_wr) begin
                first_pending <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    // Gain field drives the analog stage directly
    assign analog_attenuation = analog_gain_control[GAIN_W-1:0];
    assign mod_half_rate = converter_mod_control[FREQ_SEL_BIT];
    assign dither_main_en = converter_mod_control[DITHER_EN_LSB];
    assign dither_second_en = converter_mod_control[DITHER_EN_LSB+1];
    assign dither_level = converter_mod_control[DITHER_LVL_LSB+:3];
    assign element_matching_select = converter_mod_control[MATCH_SEL_LSB+:2];
    // Codes 01 and 10 are undefined; only 11 turns matching off
    assign element_matching = (element_matching_select != 2'h3);
    assign coef_unique = processing_bypass[SHARE_BIT];
    assign fir_bypass = processing_bypass[FIR_BYP_BIT];
    assign range_compressor_bypass = processing_bypass[COMP_BYP_BIT];
    assign eq_bypass = processing_bypass[EQ_BYP_BIT];

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Read data registered; unmapped offsets read zero
    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_ANALOG_GAIN: reg_rdata <= analog_gain_control;
                ADDR_BIQUAD_MARK: reg_rdata <= biquad_write_marker;
                ADDR_CONV_MOD: reg_rdata <= converter_mod_control;
                ADDR_PIN_DIR: reg_rdata <= addr_pin_direction;
                ADDR_PIN_FUNC: reg_rdata <= addr_pin_function;
                ADDR_PROC_BYPASS: reg_rdata <= processing_bypass;
                ADDR_SILICON_ID: reg_rdata <= SILICON_ID;
                ADDR_POWER_STATE: reg_rdata <= power_state_report;
                ADDR_MUTE_STATUS: reg_rdata <= {6'h00, right_muted_status, left_muted_status};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Address pin
    // ------------------------------------------------------------
    amc_pin_mux u_pin_mux (
        .clock(clock),
        .srst(srst),
        .pin_output_enable(addr_pin_direction[0]),
        .pin_function(addr_pin_function[FUNC_W-1:0]),
        .left_muted(left_muted_status),
        .right_muted(right_muted_status),
        .clock_invalid(flag_sync[1]),
        .fault_out_n(flag_sync[0]),
        .addr_pin_o(addr_pin_o),
        .addr_pin_oe(addr_pin_oe)
    );

    // ------------------------------------------------------------
    // Write checks
    // ------------------------------------------------------------
    // Bus is sampled on the write edge, the decoded field one edge later
    gain_write_a: assert property (@(posedge clock) disable iff (srst)
        (reg_wr && reg_addr == ADDR_ANALOG_GAIN) |=> analog_attenuation == $past(reg_wdata[GAIN_W-1:0]))
        else $error("gain write not applied");
    biquad_mark_a: assert property (@(posedge clock) disable iff (srst)
        (first_pending && coef_wr && !reg_wr) |=> biquad_new ##1 !biquad_new)
        else $error("biquad start not flagged once");
    freq_reset_a: assert property (@(posedge clock)
        srst |=> mod_half_rate && dither_main_en && dither_second_en)
        else $error("modulator reset value wrong");
    rate_write_a: assert property (@(posedge clock) disable iff (srst)
        (reg_wr && reg_addr == ADDR_CONV_MOD) |=> mod_half_rate == $past(reg_wdata[FREQ_SEL_BIT]))
        else $error("modulator rate write not applied");
    // Expected dither bits come from the bus, not from the stored register
    dither_map_a: assert property (@(posedge clock) disable iff (srst)
        (reg_wr && reg_addr == ADDR_CONV_MOD) |=>
            {dither_second_en, dither_main_en, dither_level} == $past(reg_wdata[DITHER_EN_LSB+1:DITHER_LVL_LSB]))
        else $error("dither fields misplaced");
    match_off_a: assert property (@(posedge clock) disable iff (srst)
        (element_matching_select == 2'h3) == !element_matching)
        else $error("element matching decode wrong");
    match_on_a: assert property (@(posedge clock) disable iff (srst)
        (reg_wr && reg_addr == ADDR_CONV_MOD && reg_wdata[MATCH_SEL_LSB+:2] == 2'h0) |=> element_matching)
        else $error("element matching not enabled by code zero");
    share_bit_a: assert property (@(posedge clock) disable iff (srst)
        (reg_wr && reg_addr == ADDR_PROC_BYPASS) |=>
            coef_unique == $past(reg_wdata[SHARE_BIT]) && eq_bypass == $past(reg_wdata[EQ_BYP_BIT]))
        else $error("bypass write not applied");
    bypass_mid_a: assert property (@(posedge clock) disable iff (srst)
        (reg_wr && reg_addr == ADDR_PROC_BYPASS) |=>
            fir_bypass == $past(reg_wdata[FIR_BYP_BIT])
            && range_compressor_bypass == $past(reg_wdata[COMP_BYP_BIT]))
        else $error("filter or compressor bypass write not applied");

    // ------------------------------------------------------------
    // Status and read checks
    // ------------------------------------------------------------
    // Read data lands one edge after the read strobe
    id_read_a: assert property (@(posedge clock) disable iff (srst)
        (reg_rd && reg_addr == ADDR_SILICON_ID) |=> reg_rdata == SILICON_ID)
        else $error("identifier read wrong");
    power_read_a: assert property (@(posedge clock) disable iff (srst)
        reg_rd && reg_addr == ADDR_POWER_STATE |=> reg_rdata[7:2] == 6'h00)
        else $error("power state high bits set");
    // Report register adds one edge before the read edge
    power_code_a: assert property (@(posedge clock) disable iff (srst)
        (reg_rd && reg_addr == ADDR_POWER_STATE) |=> reg_rdata[1:0] == $past(power_state_code, 2))
        else $error("power state report stale");
    ro_write_a: assert property (@(posedge clock) disable iff (srst)
        (reg_wr && reg_addr == ADDR_SILICON_ID) |=> $stable(processing_bypass) && $stable(analog_gain_control))
        else $error("read-only write disturbed registers");
    ro_state_a: assert property (@(posedge clock) disable iff (srst)
        (reg_wr && reg_addr == ADDR_MUTE_STATUS) |=> $stable(converter_mod_control) && $stable(addr_pin_function))
        else $error("status write disturbed registers");
    // Two synchroniser stages plus the status register
    mute_status_a: assert property (@(posedge clock) disable iff (srst)
        $rose(left_mute_in) ##1 left_mute_in [*2] |=> left_muted_status)
        else $error("left mute status late");
    right_mute_a: assert property (@(posedge clock) disable iff (srst)
        $rose(right_mute_in) ##1 right_mute_in [*2] |=> right_muted_status)
        else $error("right mute status late");

    // Main scenarios
    biquad_c: cover property (@(posedge clock) disable iff (srst)
        biquad_new);
    pin_out_c: cover property (@(posedge clock) disable iff (srst)
        addr_pin_oe && addr_pin_o);
    mute_c: cover property (@(posedge clock) disable iff (srst)
        right_muted_status && left_muted_status);
    ro_write_c: cover property (@(posedge clock) disable iff (srst)
        reg_wr && reg_addr == ADDR_SILICON_ID);
    match_off_c: cover property (@(posedge clock) disable iff (srst)
        !element_matching);

endmodule : amc_misc_regs

// File: bench/amc_misc_regs_tb.sv
module amc_misc_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import amc_pkg::*;

    // ------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------
    // Arbitrary identifier value, distinct from the package default
    localparam logic [7:0] TB_ID = 8'hA5;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic coef_wr = 1'b0;
    logic biquad_new;
    logic [GAIN_W-1:0] analog_attenuation;
    logic mod_half_rate, dither_main_en, dither_second_en;
    logic [2:0] dither_level;
    logic [1:0] element_matching_select;
    logic element_matching, coef_unique, fir_bypass, range_compressor_bypass, eq_bypass;
    logic [1:0] power_state_code = 2'h0;
    logic left_mute_in = 1'b0;
    logic right_mute_in = 1'b0;
    logic clock_invalid_in = 1'b0;
    logic fault_in_n = 1'b1;
    logic addr_pin_o, addr_pin_oe;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [4:0] codes [7] = '{5'h00, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0B, 5'h07};
    logic [3:0] sets [3] = '{4'b1010, 4'b0101, 4'b1100};

    amc_misc_regs #(.SILICON_ID(TB_ID)) u_amc_misc_regs (
        .clock(clock), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .coef_wr(coef_wr), .biquad_new(biquad_new),
        .analog_attenuation(analog_attenuation), .mod_half_rate(mod_half_rate),
        .dither_main_en(dither_main_en), .dither_second_en(dither_second_en),
        .dither_level(dither_level), .element_matching_select(element_matching_select),
        .element_matching(element_matching), .coef_unique(coef_unique), .fir_bypass(fir_bypass),
        .range_compressor_bypass(range_compressor_bypass), .eq_bypass(eq_bypass),
        .power_state_code(power_state_code), .left_mute_in(left_mute_in),
        .right_mute_in(right_mute_in), .clock_invalid_in(clock_invalid_in),
        .fault_in_n(fault_in_n), .addr_pin_o(addr_pin_o), .addr_pin_oe(addr_pin_oe));

    // 50 MHz system clock
    always #10 clock = ~clock;

    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(negedge clock);
    endtask : step

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Strobe for one edge, then let the field outputs settle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        step(1);
        reg_wr = 1'b0;
        step(2);
    endtask : wr

    // Read data holds until the next read, so sampling late is safe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        reg_rd = 1'b1;
        reg_addr = a;
        step(1);
        reg_rd = 1'b0;
        step(2);
        chk(reg_rdata, exp, what);
    endtask : rd

    // Count marker pulses seen over a short fixed span after one coefficient write
    task automatic coef_pulse(input logic [7:0] exp);
        logic [7:0] seen;
        seen = 8'h00;
        coef_wr = 1'b1;
        // Pulse stands from the taking edge to the next; look at each falling edge
        repeat (4) begin
            step(1);
            coef_wr = 1'b0;
            seen = seen + 8'(biquad_new);
        end
        chk(seen, exp, "biquad pulses");
    endtask : coef_pulse

    function automatic logic pin_exp(input logic [4:0] f, input logic [3:0] s);
        case (f)
            PIN_FN_MUTE_BOTH: return s[3] & s[2];
            PIN_FN_MUTE_LEFT: return s[3];
            PIN_FN_MUTE_RIGHT: return s[2];
            PIN_FN_CLK_INVALID: return s[1];
            PIN_FN_FAULT: return s[0];
            default: return 1'b0;
        endcase
    endfunction : pin_exp

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        step(8);
        srst = 1'b0;
        step(1);
        // Reset values of every register except power state, plus an unmapped offset
        rd(ADDR_ANALOG_GAIN, 8'h00, "gain reset");
        rd(ADDR_BIQUAD_MARK, 8'h00, "marker reset");
        rd(ADDR_CONV_MOD, 8'hF8, "conv reset");
        rd(ADDR_PIN_DIR, 8'h00, "dir reset");
        rd(ADDR_PIN_FUNC, 8'h00, "func reset");
        rd(ADDR_PROC_BYPASS, 8'h00, "bypass reset");
        rd(ADDR_SILICON_ID, TB_ID, "id");
        rd(ADDR_MUTE_STATUS, 8'h00, "mute reset");
        rd(8'h55, 8'h00, "unmapped");
        chk({mod_half_rate, dither_second_en, dither_main_en, dither_level, element_matching_select},
            8'hF8, "conv fields reset");
        $display("test reset done");
        // Attenuation extremes; reserved upper bits stored but not on the field
        wr(ADDR_ANALOG_GAIN, 8'h1F);
        chk(8'(analog_attenuation), 8'h1F, "max attenuation");
        wr(ADDR_ANALOG_GAIN, 8'hE0);
        chk(8'(analog_attenuation), 8'h00, "full gain");
        rd(ADDR_ANALOG_GAIN, 8'hE0, "gain readback");
        $display("test gain done");
        // Every dither enable and matching code, both rates and dither levels
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_CONV_MOD, {k[1], k[1:0], k[2], k[1:0], k[1:0]});
            chk(8'(mod_half_rate), 8'(k[1]), "rate");
            chk(8'({dither_second_en, dither_main_en}), 8'(k[1:0]), "dither en");
            chk(8'(element_matching_select), 8'(k[1:0]), "matching select");
            chk(8'(dither_level), 8'({k[2], k[1:0]}), "dither level");
            chk(8'(element_matching), 8'(k[1:0] != 2'b11), "matching");
            rd(ADDR_CONV_MOD, {k[1], k[1:0], k[2], k[1:0], k[1:0]}, "conv readback");
        end
        $display("test converter done");
        // Each bypass bit alone, in turn
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_PROC_BYPASS, 8'(1 << k));
            chk(8'({coef_unique, fir_bypass, range_compressor_bypass, eq_bypass}), 8'(1 << k),
                "bypass bits");
        end
        $display("test bypass done");
        // Marker arms one new biquad; later writes continue it; cleared gives none
        wr(ADDR_BIQUAD_MARK, 8'h01);
        coef_pulse(8'h01);
        coef_pulse(8'h00);
        rd(ADDR_BIQUAD_MARK, 8'h01, "marker kept");
        // Re-arm, then clear before any coefficient write: nothing may start
        wr(ADDR_BIQUAD_MARK, 8'h01);
        wr(ADDR_BIQUAD_MARK, 8'h00);
        coef_pulse(8'h00);
        rd(ADDR_BIQUAD_MARK, 8'h00, "marker cleared");
        $display("test biquad done");
        // Pin function codes against three sets of flag levels
        wr(ADDR_PIN_DIR, 8'h01);
        for (int s = 0; s < 3; s++) begin
            {left_mute_in, right_mute_in, clock_invalid_in, fault_in_n} = sets[s];
            step(6);
            rd(ADDR_MUTE_STATUS, {6'h00, sets[s][2], sets[s][3]}, "mute status");
            for (int c = 0; c < 7; c++) begin
                wr(ADDR_PIN_FUNC, {3'h0, codes[c]});
                step(1);
                chk(8'(addr_pin_o), 8'(pin_exp(codes[c], sets[s])), "pin level");
                chk(8'(addr_pin_oe), 8'h01, "pin driven");
            end
        end
        wr(ADDR_PIN_DIR, 8'h00);
        step(1);
        chk(8'(addr_pin_oe), 8'h00, "pin input");
        $display("test pin done");
        // Power state codes, then writes to read-only and unmapped places
        for (int k = 0; k < 4; k++) begin
            power_state_code = 2'(k);
            step(2);
            rd(ADDR_POWER_STATE, 8'(k), "power state");
        end
        wr(ADDR_SILICON_ID, 8'hFF);
        wr(ADDR_POWER_STATE, 8'hFF);
        wr(ADDR_MUTE_STATUS, 8'hFF);
        wr(8'h55, 8'hFF);
        rd(ADDR_SILICON_ID, TB_ID, "id after write");
        rd(ADDR_POWER_STATE, 8'h03, "state after write");
        rd(ADDR_MUTE_STATUS, {6'h00, sets[2][2], sets[2][3]}, "mute after write");
        rd(8'h55, 8'h00, "unmapped after write");
        $display("test read only done");
        test_done();
    end
endmodule : amc_misc_regs_tb
